/* rtl/iocrb_defines.svh */
// Constants of the I/O cell register block: sizes, offsets, fields, reset values
`ifndef IOCRB_DEFINES_SVH
`define IOCRB_DEFINES_SVH

// ==================================================================
// Sizes
`define IOCRB_CELLS          4
`define IOCRB_ADDR_W         8
`define IOCRB_DATA_W         32
`define IOCRB_CFG_W          8

// ==================================================================
// Register byte offsets
`define IOCRB_OFS_CTRL       8'h00
`define IOCRB_OFS_STATUS     8'h04
`define IOCRB_OFS_CFG_BASE   8'h10
`define IOCRB_OFS_CFG_LAST   8'h1C

// ==================================================================
// Bank control fields
`define IOCRB_CTRL_FREEZE    0

// Per-cell configuration fields
`define IOCRB_CFG_IN_POS     0
`define IOCRB_CFG_OUT_POS    2
`define IOCRB_CFG_OEREG      4
`define IOCRB_CFG_HOLDEN     5

// Status fields
`define IOCRB_STS_PADIN_POS  0
`define IOCRB_STS_OE_POS     4
`define IOCRB_STS_HOLD_POS   8
`define IOCRB_STS_CFGING     12

// ==================================================================
// Reset values
`define IOCRB_RST_CFG        8'h00
`define IOCRB_RST_FREEZE     1'h0

// AXI responses
`define IOCRB_RESP_OKAY      2'h0
`define IOCRB_RESP_SLVERR    2'h2

`endif

/* rtl/iocrb_pkg.sv */
// Types shared by the I/O cell register block modules
package iocrb_pkg;
`include "iocrb_defines.svh"

    typedef enum logic [1:0] {
        IOCRB_IN_DIRECT = 2'b00,
        IOCRB_IN_REG    = 2'b01,
        IOCRB_IN_DDR    = 2'b10,
        IOCRB_IN_RSVD   = 2'b11
    } iocrb_in_mode_t;

    typedef enum logic [1:0] {
        IOCRB_OUT_DIRECT = 2'b00,
        IOCRB_OUT_REG    = 2'b01,
        IOCRB_OUT_DDR    = 2'b10,
        IOCRB_OUT_RSVD   = 2'b11
    } iocrb_out_mode_t;

    typedef struct packed {
        logic [`IOCRB_CELLS-1:0] inQ1;
        logic [`IOCRB_CELLS-1:0] outQ1;
    } iocrb_neg_state_t;

    typedef struct packed {
        logic                    awHeld;
        logic                    wHeld;
        logic [`IOCRB_ADDR_W-1:0] wAddr;
        logic [`IOCRB_DATA_W-1:0] wData;
        logic [3:0]              wStrb;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [`IOCRB_DATA_W-1:0] rdata;
        logic [1:0]              rresp;
    } iocrb_axil_state_t;

    typedef struct packed {
        logic                                        freeze;
        logic [`IOCRB_CELLS-1:0][`IOCRB_CFG_W-1:0]   cfg;
        logic [`IOCRB_CELLS-1:0]                     inQ0;
        logic [`IOCRB_CELLS-1:0]                     outQ0;
        logic [`IOCRB_CELLS-1:0]                     oeQ;
        logic [`IOCRB_CELLS-1:0]                     held;
    } iocrb_top_state_t;

endpackage

/* rtl/iocrb_negedge_capture.sv */
// Falling-edge registers of the double-data-rate input and output paths
`timescale 1ns/1ps
`include "iocrb_defines.svh"
module iocrb_negedge_capture
    import iocrb_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    clkEnable,
    input  wire logic [`IOCRB_CELLS-1:0] padIn,
    input  wire logic [`IOCRB_CELLS-1:0] dOut1,
    output logic      [`IOCRB_CELLS-1:0] inQ1,
    output logic      [`IOCRB_CELLS-1:0] outQ1
);

    iocrb_neg_state_t st_r;
    iocrb_neg_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (clkEnable) begin
            st_nxt.inQ1  = padIn;
            st_nxt.outQ1 = dOut1;
        end
    end

    // Falling edge by intent: second half of each DDR bit period
    always_ff @(negedge core_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign inQ1  = st_r.inQ1;
    assign outQ1 = st_r.outQ1;

endmodule

/* rtl/iocrb_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
`include "iocrb_defines.svh"
module iocrb_axil_slave
    import iocrb_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic [`IOCRB_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [`IOCRB_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [`IOCRB_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [`IOCRB_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    output logic                          wrReq,
    output logic [`IOCRB_ADDR_W-1:0]      wrAddr,
    output logic [`IOCRB_DATA_W-1:0]      wrData,
    output logic [3:0]                    wrStrb,
    input  wire logic                     wrOk,
    output logic                          rdReq,
    output logic [`IOCRB_ADDR_W-1:0]      rdAddr,
    input  wire logic [`IOCRB_DATA_W-1:0] rdData,
    input  wire logic                     rdOk
);

    iocrb_axil_state_t st_r;
    iocrb_axil_state_t st_nxt;

    assign wrReq  = st_r.awHeld && st_r.wHeld && !st_r.bvalid;
    assign wrAddr = st_r.wAddr;
    assign wrData = st_r.wData;
    assign wrStrb = st_r.wStrb;
    assign rdReq  = s_axi_arvalid && st_r.arready;
    assign rdAddr = s_axi_araddr;

    always_comb begin
        st_nxt = st_r;
        // ==========================================================
        // Write: address and data in either order, response after both
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.awHeld = 1'b1;
            st_nxt.wAddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = s_axi_wdata;
            st_nxt.wStrb = s_axi_wstrb;
        end
        if (wrReq) begin
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = wrOk ? `IOCRB_RESP_OKAY : `IOCRB_RESP_SLVERR;
        end else if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // Ready drops while a word is held so a second one cannot overwrite it
        st_nxt.awready = !st_nxt.awHeld && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.wHeld && !st_nxt.bvalid;
        // ==========================================================
        // Read: answer in the cycle after the address is taken
        if (rdReq) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rdData;
            st_nxt.rresp  = rdOk ? `IOCRB_RESP_OKAY : `IOCRB_RESP_SLVERR;
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r         <= '0;
            st_r.awready <= 1'b1;
            st_r.wready  <= 1'b1;
            st_r.arready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;

endmodule

/* rtl/io_cell_register_block.sv */
// One bank of programmable I/O cells with input, output and tri-state register paths
//
// Summary of operation
// - Every cell has its own input, output and tri-state register paths between core and pad.
// - A hold latch, when engaged and allowed for the cell, freezes the level of a non-registered input.
// - One freeze control is shared by all cells of the bank and cannot be given to a single cell.
// - The input path either samples the pad in a register or passes it unregistered to the core.
// - In DDR input mode one register samples on the rising and one on the falling edge, giving two streams.
// - The output path registers core data or passes it straight to the pad, chosen per cell.
// - In DDR output mode two registers capture on opposite edges and a mux merges them at twice the rate.
// - A per-cell hold input latches and holds the value shown to the core while it is high, in a hold-enabled cell with a non-registered input.
// - During configuration the global reset holds every cell flip-flop in its wake-up state.
// - During configuration the global float control forces every pad driver to high impedance.
`timescale 1ns/1ps
`include "iocrb_defines.svh"
module io_cell_register_block
    import iocrb_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // Register bus
    input  wire logic [`IOCRB_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [`IOCRB_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [`IOCRB_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [`IOCRB_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // Device-wide configuration controls
    input  wire logic                     globalFloatControl,
    input  wire logic                     bankFreeze,
    // Core side, one bit per cell except clkEnable, which is shared by all cells
    input  wire logic                     clkEnable,
    input  wire logic [`IOCRB_CELLS-1:0]  outputEnable,
    input  wire logic [`IOCRB_CELLS-1:0]  dOut0,
    input  wire logic [`IOCRB_CELLS-1:0]  dOut1,
    input  wire logic [`IOCRB_CELLS-1:0]  latchInputValue,
    output logic      [`IOCRB_CELLS-1:0]  dIn0,
    output logic      [`IOCRB_CELLS-1:0]  dIn1,
    // Pad side
    input  wire logic [`IOCRB_CELLS-1:0]  padIn,
    output logic      [`IOCRB_CELLS-1:0]  padOut,
    output logic      [`IOCRB_CELLS-1:0]  padOe
);

    localparam int CELLS = `IOCRB_CELLS;

    iocrb_top_state_t st_r;
    iocrb_top_state_t st_nxt;

    logic                     wrReq;
    logic [`IOCRB_ADDR_W-1:0] wrAddr;
    logic [`IOCRB_DATA_W-1:0] wrData;
    logic [3:0]               wrStrb;
    logic                     wrOk;
    logic                     rdReq;
    logic [`IOCRB_ADDR_W-1:0] rdAddr;
    logic [`IOCRB_DATA_W-1:0] rdData;
    logic                     rdOk;

    logic [CELLS-1:0]         inQ1;
    logic [CELLS-1:0]         outQ1;
    logic                     freezeAll;
    logic [CELLS-1:0]         holdActive;
    logic [CELLS-1:0]         liveIn;
    logic [CELLS-1:0]         inDirect;

    // ==================================================================
    // Bus front end
    iocrb_axil_slave u_axil (
        .core_clk      (core_clk),
        .rst           (rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wrReq         (wrReq),
        .wrAddr        (wrAddr),
        .wrData        (wrData),
        .wrStrb        (wrStrb),
        .wrOk          (wrOk),
        .rdReq         (rdReq),
        .rdAddr        (rdAddr),
        .rdData        (rdData),
        .rdOk          (rdOk)
    );

    // ==================================================================
    // Falling-edge halves of the DDR paths
    iocrb_negedge_capture u_neg (
        .core_clk  (core_clk),
        .rst       (rst),
        .clkEnable (clkEnable),
        .padIn     (padIn),
        .dOut1     (dOut1),
        .inQ1      (inQ1),
        .outQ1     (outQ1)
    );

    // ==================================================================
    // Address decode
    function automatic logic isCfgAddr(input logic [`IOCRB_ADDR_W-1:0] a);
        isCfgAddr = (a >= `IOCRB_OFS_CFG_BASE) && (a <= `IOCRB_OFS_CFG_LAST) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [1:0] cfgIndex(input logic [`IOCRB_ADDR_W-1:0] a);
        logic [`IOCRB_ADDR_W-1:0] d;
        d = a - `IOCRB_OFS_CFG_BASE;
        cfgIndex = d[3:2];
    endfunction

    assign wrOk = (wrAddr == `IOCRB_OFS_CTRL) || isCfgAddr(wrAddr);
    assign rdOk = (rdAddr == `IOCRB_OFS_CTRL) || (rdAddr == `IOCRB_OFS_STATUS) || isCfgAddr(rdAddr);

    // Freeze is one bank-wide term; no cell gets its own copy
    assign freezeAll = bankFreeze || st_r.freeze;

    // ==================================================================
    // Per-cell combinational paths
    genvar gi;
    generate
        for (gi = 0; gi < CELLS; gi++) begin : g_cell
            iocrb_in_mode_t  inMode;
            iocrb_out_mode_t outMode;
            logic            oeReg;
            logic            holdEn;
            logic            oeSel;

            assign inMode  = iocrb_in_mode_t'(st_r.cfg[gi][`IOCRB_CFG_IN_POS +: 2]);
            assign outMode = iocrb_out_mode_t'(st_r.cfg[gi][`IOCRB_CFG_OUT_POS +: 2]);
            assign oeReg   = st_r.cfg[gi][`IOCRB_CFG_OEREG];
            assign holdEn  = st_r.cfg[gi][`IOCRB_CFG_HOLDEN];

            // Holding applies only to the unregistered input path
            assign inDirect[gi]   = (inMode == IOCRB_IN_DIRECT);
            assign holdActive[gi] = holdEn && inDirect[gi] && (freezeAll || latchInputValue[gi]);
            assign liveIn[gi]     = padIn[gi];

            always_comb begin
                case (inMode)
                    IOCRB_IN_DIRECT: begin
                        dIn0[gi] = holdActive[gi] ? st_r.held[gi] : liveIn[gi];
                        dIn1[gi] = 1'b0;
                    end
                    IOCRB_IN_REG: begin
                        dIn0[gi] = st_r.inQ0[gi];
                        dIn1[gi] = 1'b0;
                    end
                    IOCRB_IN_DDR: begin
                        dIn0[gi] = st_r.inQ0[gi];
                        dIn1[gi] = inQ1[gi];
                    end
                    default: begin
                        dIn0[gi] = 1'b0;
                        dIn1[gi] = 1'b0;
                    end
                endcase
            end

            // DDR launch: high phase shows the rising-edge bit, low phase the falling-edge bit
            always_comb begin
                case (outMode)
                    IOCRB_OUT_DIRECT: padOut[gi] = dOut0[gi];
                    IOCRB_OUT_REG:    padOut[gi] = st_r.outQ0[gi];
                    IOCRB_OUT_DDR:    padOut[gi] = core_clk ? st_r.outQ0[gi] : outQ1[gi];
                    default:          padOut[gi] = 1'b0;
                endcase
            end

            // Float control overrides everything so configuration never fights the board
            assign oeSel      = oeReg ? st_r.oeQ[gi] : outputEnable[gi];
            assign padOe[gi]  = oeSel && !globalFloatControl;
        end
    endgenerate

    // ==================================================================
    // Register read data
    always_comb begin
        rdData = '0;
        if (rdAddr == `IOCRB_OFS_CTRL) begin
            rdData[`IOCRB_CTRL_FREEZE] = st_r.freeze;
        end else if (rdAddr == `IOCRB_OFS_STATUS) begin
            rdData[`IOCRB_STS_PADIN_POS +: CELLS] = padIn;
            rdData[`IOCRB_STS_OE_POS +: CELLS]    = padOe;
            rdData[`IOCRB_STS_HOLD_POS +: CELLS]  = holdActive;
            rdData[`IOCRB_STS_CFGING]             = globalFloatControl;
        end else if (isCfgAddr(rdAddr)) begin
            rdData[`IOCRB_CFG_W-1:0] = st_r.cfg[cfgIndex(rdAddr)];
        end
    end

    // ==================================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        if (wrReq && wrStrb[0]) begin
            if (wrAddr == `IOCRB_OFS_CTRL) begin
                st_nxt.freeze = wrData[`IOCRB_CTRL_FREEZE];
            end else if (isCfgAddr(wrAddr)) begin
                st_nxt.cfg[cfgIndex(wrAddr)] = wrData[`IOCRB_CFG_W-1:0];
            end
        end
        // Clock enable low keeps every path register at its value
        if (clkEnable) begin
            st_nxt.inQ0  = padIn;
            st_nxt.outQ0 = dOut0;
            st_nxt.oeQ   = outputEnable;
        end
        // The held copy tracks the pad until hold engages; it shows the prior cycle's level
        for (int i = 0; i < CELLS; i++) begin
            if (!holdActive[i]) begin
                st_nxt.held[i] = liveIn[i];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r        <= '0;
            st_r.freeze <= `IOCRB_RST_FREEZE;
            for (int i = 0; i < CELLS; i++) begin
                st_r.cfg[i] <= `IOCRB_RST_CFG;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

/* sim/iocrb_pad_model.sv */
// Pad buffer and board model facing the I/O cell bank
`timescale 1ns/1ps
`include "iocrb_defines.svh"
module iocrb_pad_model
    import iocrb_pkg::*;
(
    input  wire logic [`IOCRB_CELLS-1:0] padOut,
    input  wire logic [`IOCRB_CELLS-1:0] padOe,
    input  wire logic [`IOCRB_CELLS-1:0] boardLevel,
    output logic      [`IOCRB_CELLS-1:0] padIn
);
    // ========
    // Pad level
    // Board driver wins only where the cell has released its driver
    assign padIn = (padOe & padOut) | (~padOe & boardLevel);
endmodule

/* sim/iocrb_checker_asserts.sv */
// Concurrent checks on the ports of the I/O cell bank
`timescale 1ns/1ps
`include "iocrb_defines.svh"
module iocrb_checker
    import iocrb_pkg::*;
(
    input wire logic                     core_clk,
    input wire logic                     rst,
    input wire logic                     s_axi_awvalid,
    input wire logic                     s_axi_awready,
    input wire logic                     s_axi_wvalid,
    input wire logic                     s_axi_wready,
    input wire logic [1:0]               s_axi_bresp,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_bready,
    input wire logic                     s_axi_arvalid,
    input wire logic                     s_axi_arready,
    input wire logic [`IOCRB_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]               s_axi_rresp,
    input wire logic                     s_axi_rvalid,
    input wire logic                     s_axi_rready,
    input wire logic                     globalFloatControl,
    input wire logic [`IOCRB_CELLS-1:0]  outputEnable,
    input wire logic [`IOCRB_CELLS-1:0]  padOe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ========
    // Pad driver
    chk_float_release: assert property (globalFloatControl |-> padOe == '0)
        else $error("pad driven while floating");
    chk_wake_state: assert property ($fell(rst) && !globalFloatControl |-> padOe == outputEnable)
        else $error("enable path not in wake-up state");
    // ========
    // Register bus
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response not on time");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not on time");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == `IOCRB_RESP_SLVERR);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (globalFloatControl && outputEnable != '0);
endmodule
bind io_cell_register_block iocrb_checker chk (.*);

/* sim/test_io_cell_register_block.sv */
// Self-checking bench of the I/O cell register block
`timescale 1ns/1ps
`include "iocrb_defines.svh"
module test_io_cell_register_block
    import iocrb_pkg::*;
;
    localparam logic [7:0] CFG = `IOCRB_OFS_CFG_BASE;
    localparam logic [1:0] OK  = `IOCRB_RESP_OKAY;
    localparam logic [1:0] ERR = `IOCRB_RESP_SLVERR;
    logic        core_clk = 1'h0, rst = 1'h1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        globalFloatControl = 1'h0, bankFreeze = 1'h0, clkEnable = 1'h1;
    logic [3:0]  outputEnable = 4'h0, dOut0 = 4'h0, dOut1 = 4'h0, latchInputValue = 4'h0, boardLevel = 4'h0;
    logic [3:0]  dIn0, dIn1, padIn, padOut, padOe, a, b;
    logic [33:0] rdQ[$], wrQ[$];
    int          badCount = 0, cmpCount = 0;

    io_cell_register_block dut (.*);
    iocrb_pad_model pad (.*);

    initial forever #2 core_clk = ~core_clk;
    // ========
    // Compare and closing tasks
    task automatic chkBus(input logic [33:0] got, input logic [33:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chkPin(input logic [3:0] got, input logic [3:0] exp);
        chkBus({30'h0, got}, {30'h0, exp});
    endtask
    task automatic testDone();
        if (badCount == 0 && cmpCount > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ========
    // Bus master; each call first lets an edge pass
    task automatic axWr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
        @(posedge core_clk);
        wrQ.push_back({r, 32'h0});
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 1'h0;
                break;
            end
        end
    endtask
    task automatic axRd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
        @(posedge core_clk);
        rdQ.push_back({r, d});
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rready <= 1'h0;
                break;
            end
        end
    endtask
    task automatic setCfg(input logic [7:0] m);
        for (int i = 0; i < 4; i++) axWr(CFG + 8'(4 * i), {24'h0, m}, OK);
    endtask
    // Each result meets the oldest note
    always @(posedge core_clk) begin
        if (s_axi_rvalid && s_axi_rready) chkBus({s_axi_rresp, s_axi_rdata}, rdQ.pop_front());
        if (s_axi_bvalid && s_axi_bready) chkBus({s_axi_bresp, 32'h0}, wrQ.pop_front());
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        badCount++;
        testDone();
    end
    // ========
    // Scenarios
    initial begin
        void'($urandom(32'h5DA45101));
        repeat (16) @(posedge core_clk);
        rst <= 1'h0;
        for (int i = 0; i < 4; i++) axRd(CFG + 8'(4 * i), 32'h0, OK);
        axRd(8'h08, 32'h0, ERR);
        axWr(`IOCRB_OFS_STATUS, 32'hFFFFFFFF, ERR);
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            axWr(CFG + 8'(4 * i), v, OK);
            axRd(CFG + 8'(4 * i), {24'h0, v[7:0]}, OK);
        end
        setCfg(8'h00);
        a = 4'($urandom);
        b = ~a;
        @(posedge core_clk);
        dOut0 <= a;
        outputEnable <= 4'h3;
        boardLevel <= b;
        @(posedge core_clk);
        #1 chkPin(padOut, a);
        chkPin(padOe, 4'h3);
        chkPin(dIn0, {b[3:2], a[1:0]});
        @(posedge core_clk);
        globalFloatControl <= 1'h1;
        outputEnable <= 4'hF;
        @(posedge core_clk);
        #1 chkPin(padOe, 4'h0);
        axRd(`IOCRB_OFS_STATUS, {19'h0, 1'h1, 8'h00, b}, OK);
        globalFloatControl <= 1'h0;
        outputEnable <= 4'h0;
        setCfg(8'h01);
        @(posedge core_clk);
        boardLevel <= a;
        @(posedge core_clk);
        #1 chkPin(dIn0, a);
        @(posedge core_clk);
        clkEnable <= 1'h0;
        boardLevel <= b;
        repeat (2) @(posedge core_clk);
        #1 chkPin(dIn0, a);
        @(posedge core_clk);
        clkEnable <= 1'h1;
        setCfg(8'h14);
        @(posedge core_clk);
        dOut0 <= a;
        outputEnable <= 4'hF;
        @(posedge core_clk);
        #1 chkPin(padOut, a);
        chkPin(padOe, 4'hF);
        @(posedge core_clk);
        clkEnable <= 1'h0;
        dOut0 <= b;
        outputEnable <= 4'h0;
        repeat (2) @(posedge core_clk);
        #1 chkPin(padOut, a);
        chkPin(padOe, 4'hF);
        @(posedge core_clk);
        clkEnable <= 1'h1;
        setCfg(8'h02);
        a = 4'($urandom);
        b = ~a;
        @(posedge core_clk);
        boardLevel <= a;
        @(posedge core_clk);
        boardLevel <= b;
        @(negedge core_clk);
        #1 chkPin(dIn0, a);
        chkPin(dIn1, b);
        setCfg(8'h08);
        @(posedge core_clk);
        dOut0 <= a;
        dOut1 <= b;
        @(posedge core_clk);
        #1 chkPin(padOut, a);
        @(negedge core_clk);
        #1 chkPin(padOut, b);
        setCfg(8'h20);
        @(posedge core_clk);
        boardLevel <= a;
        @(posedge core_clk);
        latchInputValue <= 4'h1;
        @(posedge core_clk);
        boardLevel <= b;
        #1 chkPin(dIn0, {b[3:1], a[0]});
        @(posedge core_clk);
        bankFreeze <= 1'h1;
        @(posedge core_clk);
        boardLevel <= a;
        #1 chkPin(dIn0, {b[3:1], a[0]});
        @(posedge core_clk);
        bankFreeze <= 1'h0;
        latchInputValue <= 4'h0;
        @(posedge core_clk);
        #1 chkPin(dIn0, a);
        axWr(`IOCRB_OFS_CTRL, 32'h1, OK);
        axRd(`IOCRB_OFS_STATUS, {20'h0, 8'hF0, a}, OK);
        @(posedge core_clk);
        rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        axRd(CFG, 32'h0, OK);
        axRd(`IOCRB_OFS_CTRL, 32'h0, OK);
        repeat (4) @(posedge core_clk);
        testDone();
    end
endmodule
